// >>> hdl/sbl_regs.svh
`ifndef SBL_REGS_SVH
`define SBL_REGS_SVH
// Opcode images of the 14-bit instruction word
`define SBL_OPC_DEC_SKIP_BITS 6'h0B
`define SBL_OPC_INC_SKIP_BITS 6'h0F
`define SBL_OPC_INC_FILE_BITS 6'h0A
`define SBL_OPC_OR_FILE_BITS 6'h04
`define SBL_OPC_OR_LIT_BITS 6'h38
`define SBL_OPC_BRANCH_BITS 3'h5
// Field positions
`define SBL_DEST_BIT 7
`define SBL_FADDR_MSB 6
`define SBL_BRANCH_MSB 10
`define SBL_PAGE_MSB 6
`define SBL_PAGE_LSB 3
// Reset values
`define SBL_ACC_RST 8'h00
`define SBL_PC_RST 15'h0000
`define SBL_ZERO_RST 1'h0
// Cycles taken by a branch or a taken skip
`define SBL_LONG_CYCLES 2'h2
`endif

// >>> hdl/sbl_pkg.sv
package sbl_pkg;
    typedef enum logic [2:0] {
        SBL_EXEC = 3'h1,
        SBL_FLUSH = 3'h2,
        SBL_HALT_UNUSED = 3'h4
    } sbl_state_t;
    typedef enum logic [2:0] {
        SBL_OP_NONE,
        SBL_OP_DEC_SKIP,
        SBL_OP_INC_SKIP,
        SBL_OP_INC,
        SBL_OP_OR_LIT,
        SBL_OP_OR_FILE,
        SBL_OP_BRANCH
    } sbl_op_t;
endpackage : sbl_pkg

// >>> hdl/sbl_core.sv
`include "sbl_regs.svh"

module sbl_core import sbl_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Instruction fetch
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    // Register file read port and page latch
    input wire logic [7:0] file_rdata,
    input wire logic [6:0] program_counter_page_latch,
    // Register file write port
    output logic [6:0] file_addr,
    output logic file_we,
    output logic [7:0] file_wdata,
    // Core state
    output logic [7:0] acc_reg,
    output logic zero_flag_reg,
    output logic [14:0] pc_reg,
    output logic flush_reg,
    output logic instr_done
);
    sbl_state_t state_reg, state_next;
    logic [7:0] acc_next;
    logic zero_next;
    logic [14:0] pc_next;

    // Decode
    wire live = instr_valid && (state_reg == SBL_EXEC);
    wire is_dec_skip = instr_word[13:8] == `SBL_OPC_DEC_SKIP_BITS;
    wire is_inc_skip = instr_word[13:8] == `SBL_OPC_INC_SKIP_BITS;
    wire is_inc = instr_word[13:8] == `SBL_OPC_INC_FILE_BITS;
    wire is_or_file = instr_word[13:8] == `SBL_OPC_OR_FILE_BITS;
    wire is_or_lit = instr_word[13:8] == `SBL_OPC_OR_LIT_BITS;
    wire is_branch = instr_word[13:11] == `SBL_OPC_BRANCH_BITS;
    wire to_file = instr_word[`SBL_DEST_BIT];
    wire file_op = is_dec_skip | is_inc_skip | is_inc | is_or_file;

    // Datapath
    wire [7:0] dec_val = file_rdata - 8'h01;
    wire [7:0] inc_val = file_rdata + 8'h01;
    wire [7:0] or_file_val = acc_reg | file_rdata;
    wire [7:0] or_lit_val = acc_reg | instr_word[7:0];
    wire [7:0] file_result = is_dec_skip ? dec_val : (is_or_file ? or_file_val : inc_val);
    wire skip_taken = (is_dec_skip && dec_val == 8'h00) || (is_inc_skip && inc_val == 8'h00);
    wire sets_zero = is_inc | is_or_file | is_or_lit;
    wire [7:0] zero_src = is_or_lit ? or_lit_val : file_result;

    // Register file write: destination bit picks the target
    assign file_addr = instr_word[`SBL_FADDR_MSB:0];
    assign file_we = live && file_op && to_file;
    assign file_wdata = file_result;
    assign instr_done = instr_valid && state_reg != SBL_HALT_UNUSED;

    always_comb begin
        acc_next = acc_reg;
        zero_next = zero_flag_reg;
        pc_next = pc_reg;
        state_next = SBL_EXEC;
        if (live) begin
            pc_next = pc_reg + 15'h0001;
            if (file_op && !to_file) begin
                acc_next = file_result;
            end
            if (is_or_lit) begin
                acc_next = or_lit_val;
            end
            if (sets_zero) begin
                zero_next = zero_src == 8'h00;
            end
            if (is_branch) begin
                // The fetched word after a branch is stale, so it is flushed
                pc_next = {program_counter_page_latch[`SBL_PAGE_MSB:`SBL_PAGE_LSB],
                           instr_word[`SBL_BRANCH_MSB:0]};
                state_next = SBL_FLUSH;
            end
            if (skip_taken) begin
                state_next = SBL_FLUSH;
            end
        end else if (instr_valid) begin
            // Flushed slot executes as a no-op but still advances the PC
            pc_next = pc_reg + 15'h0001;
        end else if (state_reg == SBL_FLUSH) begin
            state_next = SBL_FLUSH;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= SBL_EXEC;
            acc_reg <= `SBL_ACC_RST;
            zero_flag_reg <= `SBL_ZERO_RST;
            pc_reg <= `SBL_PC_RST;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            zero_flag_reg <= zero_next;
            pc_reg <= pc_next;
        end
    end
    assign flush_reg = state_reg == SBL_FLUSH;

    sequence s_dec_zero;
        live && is_dec_skip && file_rdata == 8'h01;
    endsequence
    sequence s_inc_zero;
        live && is_inc_skip && file_rdata == 8'hFF;
    endsequence
    // Branch followed by the word that it makes stale
    sequence s_branch_slot;
        live && is_branch ##1 instr_valid;
    endsequence
    // Any word that arrives while the flush is pending
    sequence s_flushed_word;
        flush_reg && instr_valid;
    endsequence

    dec_skip_flush_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_dec_zero |=> flush_reg) else $error("zero decrement did not flush");
    inc_skip_flush_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_inc_zero |=> flush_reg) else $error("zero increment did not flush");
    no_skip_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && (is_dec_skip || is_inc_skip) && file_rdata != 8'h01 && file_rdata != 8'hFF
        |=> !flush_reg) else $error("nonzero skip flushed");
    dec_value_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_dec_skip && to_file |-> file_we && file_wdata == file_rdata - 8'h01)
        else $error("decrement value wrong");
    inc_value_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && (is_inc || is_inc_skip) && !to_file |=> acc_reg == $past(file_rdata) + 8'h01)
        else $error("increment value wrong");
    dest_acc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && file_op && !to_file |-> !file_we) else $error("file written with d clear");
    branch_pc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_branch |=> pc_reg[10:0] == $past(instr_word[10:0]))
        else $error("branch low bits wrong");
    branch_page_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_branch |=> pc_reg[14:11] == $past(program_counter_page_latch[6:3]))
        else $error("branch page bits wrong");
    branch_flags_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_branch |=> flush_reg && $stable(zero_flag_reg)) else $error("branch timing or flags");
    or_lit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_or_lit |=> acc_reg == ($past(acc_reg) | $past(instr_word[7:0])))
        else $error("literal OR wrong");
    or_file_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_or_file && to_file |-> file_wdata == (acc_reg | file_rdata))
        else $error("file OR wrong");
    zero_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && (is_dec_skip || is_inc_skip) |=> $stable(zero_flag_reg)) else $error("skip touched zero");

    // Decrement result routed to the accumulator instead of the file when the destination bit is clear
    dec_acc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_dec_skip && !to_file |=> acc_reg == $past(file_rdata) - 8'h01)
        else $error("decrement to accumulator wrong");

    // Increment written back to the file register
    inc_file_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && (is_inc || is_inc_skip) && to_file |-> file_we && file_wdata == file_rdata + 8'h01)
        else $error("increment to file wrong");

    // Destination bit set: the addressed register is written, accumulator kept
    dest_file_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && file_op && to_file |=> acc_reg == $past(acc_reg))
        else $error("accumulator changed with d set");

    // A discarded slot must neither write the file nor touch the accumulator
    flushed_no_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_flushed_word |-> !file_we) else $error("flushed slot wrote file");
    flushed_state_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_flushed_word |=> $stable(acc_reg) && $stable(zero_flag_reg))
        else $error("flushed slot changed state");

    // Only one slot is discarded, so the flush drops after it
    flush_ends_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_flushed_word |=> !flush_reg) else $error("flush held too long");

    // Non-branch words step the program counter by one
    pc_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        instr_valid && !(live && is_branch) |=> pc_reg == $past(pc_reg) + 15'h0001)
        else $error("program counter step wrong");

    // Branch costs exactly its own cycle plus the discarded one
    branch_slot_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_branch_slot |=> !flush_reg) else $error("branch took wrong cycles");

    // File OR routed to the accumulator
    or_file_acc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_or_file && !to_file |=> acc_reg == ($past(acc_reg) | $past(file_rdata)))
        else $error("file OR to accumulator wrong");

    // Zero flag follows the result of the flag-setting operations
    inc_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_inc |=> zero_flag_reg == ($past(file_rdata) == 8'hFF))
        else $error("increment zero flag wrong");
    or_lit_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        live && is_or_lit |=> zero_flag_reg == (acc_reg == 8'h00))
        else $error("literal OR zero flag wrong");
endmodule : sbl_core

// >>> dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Inputs
    logic ref_clk, sys_rst, instr_valid;
    logic [13:0] instr_word;
    logic [7:0] file_rdata;
    logic [6:0] program_counter_page_latch;
    // Outputs
    logic [6:0] file_addr;
    logic file_we, zero_flag_reg, flush_reg, instr_done;
    logic [7:0] file_wdata, acc_reg;
    logic [14:0] pc_reg;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int m_acc, m_z, m_pc, m_fl, res, r;
    logic we_e, fop;
    logic [5:0] op;
    logic [5:0] ops[6] = '{6'h0B, 6'h0F, 6'h0A, 6'h04, 6'h38, 6'h3F};
    logic [7:0] vals[3] = '{8'h00, 8'h01, 8'hFF};
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

    sbl_core i_sbl_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .file_rdata(file_rdata), .program_counter_page_latch(program_counter_page_latch),
        .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .acc_reg(acc_reg),
        .zero_flag_reg(zero_flag_reg), .pc_reg(pc_reg), .flush_reg(flush_reg), .instr_done(instr_done));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task end_of_test;
        $display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // Ceiling well above the 2000-cycle stream
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        r = $urandom(33126);
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        file_rdata = 8'h00;
        program_counter_page_latch = 7'h00;
        m_acc = 0; m_z = 0; m_pc = 0; m_fl = 0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2000) begin
            @(posedge ref_clk);
            r = $urandom % 7;
            instr_valid <= ($urandom % 8) != 0;
            instr_word <= (r == 6) ? {3'h5, 11'($urandom)} : {ops[r], 8'($urandom)};
            // Bias the operand toward values that make skip results zero
            r = $urandom % 4;
            file_rdata <= (r == 3) ? 8'($urandom) : vals[r];
            program_counter_page_latch <= 7'($urandom);
            @(negedge ref_clk);
            `CHK("acc", 8'(m_acc), acc_reg)
            `CHK("zero", 1'(m_z), zero_flag_reg)
            `CHK("pc", 15'(m_pc), pc_reg)
            `CHK("flush", 1'(m_fl), flush_reg)
            op = instr_word[13:8];
            fop = op inside {6'h0B, 6'h0F, 6'h0A, 6'h04};
            case (op)
                6'h0B: res = (file_rdata - 1) & 255;
                6'h0F, 6'h0A: res = (file_rdata + 1) & 255;
                6'h04: res = m_acc | file_rdata;
                default: res = m_acc | instr_word[7:0];
            endcase
            we_e = instr_valid && m_fl == 0 && fop && instr_word[7];
            `CHK("file_addr", instr_word[6:0], file_addr)
            `CHK("file_we", we_e, file_we)
            `CHK("instr_done", instr_valid, instr_done)
            if (we_e) `CHK("file_wdata", 8'(res), file_wdata)
            if (instr_valid) begin
                m_pc = (m_pc + 1) & 32767;
                if (m_fl != 0) begin
                    m_fl = 0;
                end else begin
                    if ((fop && !instr_word[7]) || op == 6'h38) m_acc = res;
                    if (op inside {6'h0A, 6'h04, 6'h38}) m_z = (res == 0);
                    if (op inside {6'h0B, 6'h0F}) m_fl = (res == 0);
                    if (instr_word[13:11] == 3'h5) begin
                        m_pc = {program_counter_page_latch[6:3], instr_word[10:0]};
                        m_fl = 1;
                    end
                end
            end
        end
        $display("test random_stream done");
        end_of_test();
    end
endmodule : tb
